// file: hdl/irq_bank_cfg.svh
// Purpose: Offsets, field positions and reset values of the peripheral interrupt enable bank.
// Assumes: Four-bit register address, eight-bit register data.
// Notes:   Definitions only; included by bare name.
`ifndef IRQ_BANK_CFG_SVH
`define IRQ_BANK_CFG_SVH

// Register offsets
`define OFS_ENABLE_1        4'h0
`define OFS_ENABLE_2        4'h1
`define OFS_ENABLE_3        4'h2
`define OFS_ENABLE_4        4'h3
`define OFS_FLAG_1          4'h4
`define OFS_FLAG_2          4'h5
`define OFS_FLAG_3          4'h6
`define OFS_FLAG_4          4'h7
`define OFS_MAIN_CTRL       4'h8
`define OFS_STATUS          4'h9

// Reset values
`define RST_BYTE            8'h00

// Implemented bits of each bank
`define IMPL_BANK_1         8'hff
`define IMPL_BANK_2         8'hef
`define IMPL_BANK_3         8'h3f
`define IMPL_BANK_4         8'hff

// Main control fields
`define GLOBAL_GATE_BIT     7
`define GROUP_GATE_BIT      6

// Status fields
`define STAT_REQUEST_BIT    0
`define STAT_ANY_BIT        1

// Bank 1 source positions
`define TIMER1_GATE_ACQ_BIT 7
`define ADC_DONE_BIT        6
`define SERIAL_RX_BIT       5
`define SERIAL_TX_BIT       4
`define SYNC_SERIAL_BIT     3
`define CAPTURE_UNIT1_BIT   2
`define TIMER2_MATCH_BIT    1
`define TIMER1_OVERFLOW_BIT 0

// Bank 2 source positions
`define OSC_FAIL_BIT        7
`define COMPARATOR2_BIT     6
`define COMPARATOR1_BIT     5
`define BUS_COLLISION_BIT   3
`define TIMER6_MATCH_BIT    2
`define TIMER4_MATCH_BIT    1
`define CAPTURE_UNIT2_BIT   0

// Bank 3 source positions
`define WAVEFORM_GEN_BIT    5
`define ZERO_CROSS_BIT      4
`define LOGIC_CELL4_BIT     3
`define LOGIC_CELL3_BIT     2
`define LOGIC_CELL2_BIT     1
`define LOGIC_CELL1_BIT     0

// Bank 4 source positions
`define MEMORY_SCANNER_BIT  7
`define CHECKSUM_UNIT_BIT   6
`define MEASURE2_WIDTH_BIT  5
`define MEASURE2_PERIOD_BIT 4
`define MEASURE2_MATCH_BIT  3
`define MEASURE1_WIDTH_BIT  2
`define MEASURE1_PERIOD_BIT 1
`define MEASURE1_MATCH_BIT  0

`endif

// file: hdl/irq_bank_pkg.sv
// Purpose: Types shared by the peripheral interrupt enable bank.
// Assumes: Constants come from irq_bank_cfg.svh.
// Notes:   No constants here, only types.
package irq_bank_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [3:0][7:0] bank_t;

  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    byte_t      wdata;
  } bus_req_s;

  typedef struct packed
  {
    byte_t flags;
  } flag_state_s;

  typedef struct packed
  {
    bank_t enable;
    logic  global_irq_gate;
    logic  peripheral_group_gate;
    byte_t rd_data;
    logic  irq;
    logic  any_unmasked;
  } bank_state_s;

endpackage

// file: hdl/sticky_flag_byte.sv
// Purpose: One byte of sticky event flags, cleared by writing ones.
// Assumes: Set pulses come from logic on the same clock.
// Notes:   A set in the same cycle as its clear wins.
`timescale 1ns/1ps
`include "irq_bank_cfg.svh"
module sticky_flag_byte
#(
  parameter logic [7:0] IMPL_MASK = 8'hff
)
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rstn,
  // Events and clear
  input  wire irq_bank_pkg::byte_t set_pulse,
  input  wire logic                clr_wr,
  input  wire irq_bank_pkg::byte_t clr_data,
  // Flags
  output irq_bank_pkg::byte_t      flags
);

  irq_bank_pkg::flag_state_s st_reg;
  irq_bank_pkg::flag_state_s st_next;

  always_comb
  begin
    st_next = st_reg;
    if (clr_wr)
    begin
      st_next.flags = st_next.flags & ~clr_data;
    end
    // Set regardless of any enable or gate, see RQ9
    st_next.flags = (st_next.flags | set_pulse) & IMPL_MASK;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg <= '{flags: `RST_BYTE};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.flags;

endmodule

// file: hdl/periph_irq_enable_bank.sv
// Purpose: Four banks of peripheral interrupt enables, their flags and the request to the core.
// Assumes: Event inputs are one-cycle pulses from logic on the same clock.
// Notes:   Register port answers reads one cycle later and never stalls.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "irq_bank_cfg.svh"

// Notes on behaviour
// RQ1 - Enable bits have no effect unless the peripheral group gate is set; status bit 1 still shows enabled flags while the group gate is clear.
// RQ2 - Every implemented enable bit is read and write and resets to zero on any reset.
// RQ3 - Bit 4 of the second bank and bits 7 and 6 of the third bank always read zero.
// RQ4 - An enable bit of one lets its source through and zero blocks it.
// RQ5 - The first bank holds timer1 gate, ADC, serial rx, serial tx, sync serial, capture 1, timer2, timer1 overflow.
// RQ6 - The second bank holds oscillator fail, comparators 2 and 1, bus collision, timer6, timer4, capture 2.
// RQ7 - The third bank holds waveform generator, zero cross and logic cells 4 to 1.
// RQ8 - The fourth bank holds scanner, CRC and the width, period and match sources of both measure timers.
// RQ9 - A flag sets on its event whatever the state of any enable or gate.
// RQ10 - With the global gate clear no peripheral request reaches the core.
// RQ11 - The request is the OR of flag and enable, qualified by the group gate, then by the global gate; the code ORs each flag ANDed with its enable.
module periph_irq_enable_bank
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rstn,
  // Register port
  input  wire irq_bank_pkg::bus_req_s reg_req,
  output irq_bank_pkg::byte_t         rd_data,
  // Core handshake
  input  wire logic                   irq_taken,
  input  wire logic                   irq_return,
  // Bank 1 events
  input  wire logic                   timer1_gate_acq_evt,
  input  wire logic                   adc_done_evt,
  input  wire logic                   serial_rx_evt,
  input  wire logic                   serial_tx_evt,
  input  wire logic                   sync_serial_evt,
  input  wire logic                   capture_unit1_evt,
  input  wire logic                   timer2_match_evt,
  input  wire logic                   timer1_overflow_evt,
  // Bank 2 events
  input  wire logic                   osc_fail_evt,
  input  wire logic                   comparator2_evt,
  input  wire logic                   comparator1_evt,
  input  wire logic                   bus_collision_evt,
  input  wire logic                   timer6_match_evt,
  input  wire logic                   timer4_match_evt,
  input  wire logic                   capture_unit2_evt,
  // Bank 3 events
  input  wire logic                   waveform_gen_evt,
  input  wire logic                   zero_cross_evt,
  input  wire logic                   logic_cell4_evt,
  input  wire logic                   logic_cell3_evt,
  input  wire logic                   logic_cell2_evt,
  input  wire logic                   logic_cell1_evt,
  // Bank 4 events
  input  wire logic                   memory_scanner_evt,
  input  wire logic                   checksum_unit_evt,
  input  wire logic                   measure2_width_acq_evt,
  input  wire logic                   measure2_period_acq_evt,
  input  wire logic                   measure2_match_evt,
  input  wire logic                   measure1_width_acq_evt,
  input  wire logic                   measure1_period_acq_evt,
  input  wire logic                   measure1_match_evt,
  // Request to core
  output logic                        irq_to_core
);

  localparam irq_bank_pkg::bank_t IMPL = {`IMPL_BANK_4, `IMPL_BANK_3, `IMPL_BANK_2, `IMPL_BANK_1};

  irq_bank_pkg::bank_state_s st_reg;
  irq_bank_pkg::bank_state_s st_next;
  irq_bank_pkg::bank_t       events;
  irq_bank_pkg::bank_t       flags;
  logic [3:0]                flag_clr;
  logic [3:0]                enable_wr;
  logic                      ctrl_wr;
  logic [3:0]                enable_rd;
  logic [3:0]                flag_rd;
  logic                      ctrl_rd;
  logic                      status_rd;
  irq_bank_pkg::bank_t       masked;
  irq_bank_pkg::bank_t       enable_view;
  logic [3:0]                bank_pending;
  logic                      any_pending;
  logic                      group_req;
  logic                      core_req;
  irq_bank_pkg::byte_t       ctrl_view;
  irq_bank_pkg::byte_t       status_view;

  // Source placement in each bank
  always_comb
  begin
    events = '0;
    // see RQ5
    events[0][`TIMER1_GATE_ACQ_BIT] = timer1_gate_acq_evt;
    events[0][`ADC_DONE_BIT]        = adc_done_evt;
    events[0][`SERIAL_RX_BIT]       = serial_rx_evt;
    events[0][`SERIAL_TX_BIT]       = serial_tx_evt;
    events[0][`SYNC_SERIAL_BIT]     = sync_serial_evt;
    events[0][`CAPTURE_UNIT1_BIT]   = capture_unit1_evt;
    events[0][`TIMER2_MATCH_BIT]    = timer2_match_evt;
    events[0][`TIMER1_OVERFLOW_BIT] = timer1_overflow_evt;
    // see RQ6
    events[1][`OSC_FAIL_BIT]        = osc_fail_evt;
    events[1][`COMPARATOR2_BIT]     = comparator2_evt;
    events[1][`COMPARATOR1_BIT]     = comparator1_evt;
    events[1][`BUS_COLLISION_BIT]   = bus_collision_evt;
    events[1][`TIMER6_MATCH_BIT]    = timer6_match_evt;
    events[1][`TIMER4_MATCH_BIT]    = timer4_match_evt;
    events[1][`CAPTURE_UNIT2_BIT]   = capture_unit2_evt;
    // see RQ7
    events[2][`WAVEFORM_GEN_BIT]    = waveform_gen_evt;
    events[2][`ZERO_CROSS_BIT]      = zero_cross_evt;
    events[2][`LOGIC_CELL4_BIT]     = logic_cell4_evt;
    events[2][`LOGIC_CELL3_BIT]     = logic_cell3_evt;
    events[2][`LOGIC_CELL2_BIT]     = logic_cell2_evt;
    events[2][`LOGIC_CELL1_BIT]     = logic_cell1_evt;
    // see RQ8
    events[3][`MEMORY_SCANNER_BIT]  = memory_scanner_evt;
    events[3][`CHECKSUM_UNIT_BIT]   = checksum_unit_evt;
    events[3][`MEASURE2_WIDTH_BIT]  = measure2_width_acq_evt;
    events[3][`MEASURE2_PERIOD_BIT] = measure2_period_acq_evt;
    events[3][`MEASURE2_MATCH_BIT]  = measure2_match_evt;
    events[3][`MEASURE1_WIDTH_BIT]  = measure1_width_acq_evt;
    events[3][`MEASURE1_PERIOD_BIT] = measure1_period_acq_evt;
    events[3][`MEASURE1_MATCH_BIT]  = measure1_match_evt;
  end

  // Write decode, one strobe per writable register; status and unmapped offsets strobe nothing
  always_comb
  begin
    flag_clr  = '0;
    enable_wr = '0;
    ctrl_wr   = 1'b0;
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        `OFS_ENABLE_1:  enable_wr[0] = 1'b1;
        `OFS_ENABLE_2:  enable_wr[1] = 1'b1;
        `OFS_ENABLE_3:  enable_wr[2] = 1'b1;
        `OFS_ENABLE_4:  enable_wr[3] = 1'b1;
        `OFS_FLAG_1:    flag_clr[0]  = 1'b1;
        `OFS_FLAG_2:    flag_clr[1]  = 1'b1;
        `OFS_FLAG_3:    flag_clr[2]  = 1'b1;
        `OFS_FLAG_4:    flag_clr[3]  = 1'b1;
        `OFS_MAIN_CTRL: ctrl_wr      = 1'b1;
        default:        ctrl_wr      = 1'b0;
      endcase
    end
  end

  // Read decode; status is read only and has no write strobe
  always_comb
  begin
    enable_rd = '0;
    flag_rd   = '0;
    ctrl_rd   = 1'b0;
    status_rd = 1'b0;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        `OFS_ENABLE_1:  enable_rd[0] = 1'b1;
        `OFS_ENABLE_2:  enable_rd[1] = 1'b1;
        `OFS_ENABLE_3:  enable_rd[2] = 1'b1;
        `OFS_ENABLE_4:  enable_rd[3] = 1'b1;
        `OFS_FLAG_1:    flag_rd[0]   = 1'b1;
        `OFS_FLAG_2:    flag_rd[1]   = 1'b1;
        `OFS_FLAG_3:    flag_rd[2]   = 1'b1;
        `OFS_FLAG_4:    flag_rd[3]   = 1'b1;
        `OFS_MAIN_CTRL: ctrl_rd      = 1'b1;
        `OFS_STATUS:    status_rd    = 1'b1;
        default:        status_rd    = 1'b0;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_flag
      sticky_flag_byte
      #(
        .IMPL_MASK (IMPL[gi])
      )
      u_flags
      (
        .clock     (clock),
        .rstn      (rstn),
        .set_pulse (events[gi]),
        .clr_wr    (flag_clr[gi]),
        .clr_data  (reg_req.wdata),
        .flags     (flags[gi])
      );
    end
  endgenerate

  // Per-bank pending requests, active high, see RQ4
  always_comb
  begin
    masked = flags & st_reg.enable;
    for (int b = 0; b < 4; b++)
    begin
      bank_pending[b] = |masked[b];
    end
    any_pending = |bank_pending;
  end

  // Group gate first, then global gate, see RQ11 see RQ1 see RQ10
  always_comb
  begin
    group_req = st_reg.peripheral_group_gate & any_pending;
    core_req  = st_reg.global_irq_gate & group_req;
  end

  // Read views; positions outside the fields read zero, see RQ3
  always_comb
  begin
    enable_view                  = st_reg.enable & IMPL;
    ctrl_view                    = `RST_BYTE;
    ctrl_view[`GLOBAL_GATE_BIT]  = st_reg.global_irq_gate;
    ctrl_view[`GROUP_GATE_BIT]   = st_reg.peripheral_group_gate;
  end

  // Status shows registered copies, so it trails the flags by a cycle
  always_comb
  begin
    status_view                    = `RST_BYTE;
    status_view[`STAT_REQUEST_BIT] = st_reg.irq;
    status_view[`STAT_ANY_BIT]     = st_reg.any_unmasked;
  end

  always_comb
  begin
    st_next = st_reg;

    // Register writes, unimplemented positions never store, see RQ2 see RQ3
    for (int b = 0; b < 4; b++)
    begin
      if (enable_wr[b])
      begin
        st_next.enable[b] = reg_req.wdata & IMPL[b];
      end
    end
    if (ctrl_wr)
    begin
      st_next.global_irq_gate       = reg_req.wdata[`GLOBAL_GATE_BIT];
      st_next.peripheral_group_gate = reg_req.wdata[`GROUP_GATE_BIT];
    end

    // Core entry clears the global gate and return restores it; entry wins
    if (irq_return)
    begin
      st_next.global_irq_gate = 1'b1;
    end
    if (irq_taken)
    begin
      st_next.global_irq_gate = 1'b0;
    end

    // Read data stand one cycle only, zero otherwise
    st_next.rd_data = `RST_BYTE;
    // Strobes are one-hot, so at most one branch hits
    for (int b = 0; b < 4; b++)
    begin
      if (enable_rd[b])
      begin
        // see RQ3
        st_next.rd_data = enable_view[b];
      end
      if (flag_rd[b])
      begin
        st_next.rd_data = flags[b];
      end
    end

    if (ctrl_rd)
    begin
      st_next.rd_data = ctrl_view;
    end
    if (status_rd)
    begin
      st_next.rd_data = status_view;
    end

    // Registered so the output pin comes straight from a flop
    st_next.any_unmasked = any_pending;
    st_next.irq          = core_req;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      // All state clears on any reset, see RQ2
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rd_data     = st_reg.rd_data;
  assign irq_to_core = st_reg.irq;

endmodule

// file: dv/event_source_model.sv
// Purpose: Peripheral event sources and core entry model.
// Assumes: One clock shared with the bank.
// Notes:   Core enters once per rising request, only while allowed.
`timescale 1ns/1ps
module event_source_model
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rstn,
  // Bench side
  input  wire irq_bank_pkg::bank_t fire,
  input  wire logic                ack_en,
  // Bank side
  input  wire logic                irq_to_core,
  output irq_bank_pkg::bank_t      evt,
  output logic                     irq_taken
);
  logic seen;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      evt <= '0;
      irq_taken <= 1'b0;
      seen <= 1'b0;
    end
    else
    begin
      evt <= fire;
      // Edge only, else a held request re-enters every cycle
      irq_taken <= ack_en && irq_to_core && !seen;
      seen <= irq_to_core;
    end
endmodule

// file: dv/periph_irq_enable_bank_chk.sv
// Purpose: Port checks of the peripheral interrupt enable bank.
// Assumes: One clock, async active-low reset.
// Notes:   Bound to the top module.
`timescale 1ns/1ps
module periph_irq_enable_bank_chk
(
  // Clock and reset
  input wire logic                   clock,
  input wire logic                   rstn,
  // Register port and core
  input wire irq_bank_pkg::bus_req_s reg_req,
  input wire irq_bank_pkg::byte_t    rd_data,
  input wire logic                   irq_taken,
  input wire logic                   irq_return,
  input wire logic                   irq_to_core
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_wr_rd(a);
    reg_req.wr && reg_req.addr == a ##1 !reg_req.wr ##1 reg_req.rd && reg_req.addr == a;
  endsequence
  sequence s_ctrl_wr;
    reg_req.wr && reg_req.addr == 4'h8;
  endsequence
  a_rd_idle_zero: assert property (!reg_req.rd |=> rd_data == 8'h00)
    else $error("read data not idle");
  a_unmapped_rd: assert property (reg_req.rd && reg_req.addr >= 4'ha |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_bank2_hole: assert property (reg_req.rd && reg_req.addr == 4'h1 |=> !rd_data[4])
    else $error("bank 2 hole set");
  a_bank3_hole: assert property (reg_req.rd && reg_req.addr == 4'h2 |=> rd_data[7:6] == 2'b00)
    else $error("bank 3 hole set");
  a_bank1_back: assert property (s_wr_rd(4'h0) |=> rd_data == $past(reg_req.wdata, 3))
    else $error("bank 1 readback");
  a_bank2_back: assert property (s_wr_rd(4'h1) |=> rd_data == ($past(reg_req.wdata, 3) & 8'hef))
    else $error("bank 2 readback");
  a_taken_masks: assert property (irq_taken ##1 !irq_return |=> !irq_to_core)
    else $error("request after entry");
  a_global_off: assert property ((s_ctrl_wr and !reg_req.wdata[7] && !irq_return) ##1 !irq_return
    && !(reg_req.wr && reg_req.addr == 4'h8) |=> !irq_to_core) else $error("global gate ignored");
  a_group_off: assert property (s_ctrl_wr ##0 !reg_req.wdata[6] ##1 !(reg_req.wr && reg_req.addr == 4'h8)
    |=> !irq_to_core) else $error("group gate ignored");
endmodule
bind periph_irq_enable_bank periph_irq_enable_bank_chk periph_irq_enable_bank_chk_i (.clock(clock), .rstn(rstn),
  .reg_req(reg_req), .rd_data(rd_data), .irq_taken(irq_taken), .irq_return(irq_return), .irq_to_core(irq_to_core));

// file: dv/testbench.sv
// Purpose: Register and request tests of the peripheral interrupt enable bank.
// Assumes: Reads answer one cycle later; events pass the source model.
// Notes:   Each access leaves an idle cycle so no strobe is driven twice at one edge.
`timescale 1ns/1ps
`include "irq_bank_cfg.svh"
module testbench;
  logic                   clock;
  logic                   rstn;
  irq_bank_pkg::bus_req_s reg_req;
  irq_bank_pkg::byte_t    rd_data;
  irq_bank_pkg::bank_t    fire;
  irq_bank_pkg::bank_t    evt;
  irq_bank_pkg::byte_t    impl [4];
  logic                   ack_en;
  logic                   irq_return;
  logic                   irq_taken;
  logic                   irq_to_core;
  int                     mismatches;
  int                     n_tests;

  event_source_model event_source_model_i (.clock(clock), .rstn(rstn), .fire(fire), .ack_en(ack_en),
    .irq_to_core(irq_to_core), .evt(evt), .irq_taken(irq_taken));
  periph_irq_enable_bank periph_irq_enable_bank_i
  (
    .clock(clock), .rstn(rstn), .reg_req(reg_req), .rd_data(rd_data), .irq_taken(irq_taken),
    .irq_return(irq_return), .irq_to_core(irq_to_core),
    .timer1_gate_acq_evt(evt[0][7]), .adc_done_evt(evt[0][6]), .serial_rx_evt(evt[0][5]),
    .serial_tx_evt(evt[0][4]), .sync_serial_evt(evt[0][3]), .capture_unit1_evt(evt[0][2]),
    .timer2_match_evt(evt[0][1]), .timer1_overflow_evt(evt[0][0]), .osc_fail_evt(evt[1][7]),
    .comparator2_evt(evt[1][6]), .comparator1_evt(evt[1][5]), .bus_collision_evt(evt[1][3]),
    .timer6_match_evt(evt[1][2]), .timer4_match_evt(evt[1][1]), .capture_unit2_evt(evt[1][0]),
    .waveform_gen_evt(evt[2][5]), .zero_cross_evt(evt[2][4]), .logic_cell4_evt(evt[2][3]),
    .logic_cell3_evt(evt[2][2]), .logic_cell2_evt(evt[2][1]), .logic_cell1_evt(evt[2][0]),
    .memory_scanner_evt(evt[3][7]), .checksum_unit_evt(evt[3][6]), .measure2_width_acq_evt(evt[3][5]),
    .measure2_period_acq_evt(evt[3][4]), .measure2_match_evt(evt[3][3]),
    .measure1_width_acq_evt(evt[3][2]), .measure1_period_acq_evt(evt[3][1]), .measure1_match_evt(evt[3][0])
  );

  task automatic results();
    $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    reg_req <= '0;
    @(posedge clock);
  endtask

  task automatic rc(input logic [3:0] a, input logic [7:0] exp);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    reg_req <= '0;
    #1 chk(rd_data, exp);
    @(posedge clock);
  endtask

  // Sampled just after the edge so the registered request has landed
  task automatic ic(input logic e);
    #1 chk({7'h00, irq_to_core}, {7'h00, e});
    @(posedge clock);
  endtask

  task automatic fi(input int b, input logic [7:0] m);
    fire[b] <= m;
    @(posedge clock);
    fire <= '0;
    repeat (3) @(posedge clock);
  endtask

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    results();
  end

  initial
  begin
    rstn = 1'b0;
    reg_req = '0;
    fire = '0;
    ack_en = 1'b0;
    irq_return = 1'b0;
    mismatches = 0;
    n_tests = 0;
    impl = '{`IMPL_BANK_1, `IMPL_BANK_2, `IMPL_BANK_3, `IMPL_BANK_4};
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    for (int b = 0; b < 4; b++)
    begin
      rc(4'(b), 8'h00);
      wr(4'(b), 8'hff);
      rc(4'(b), impl[b]);
    end
    wr(4'ha, 8'hff);
    rc(4'ha, 8'h00);
    $display("test registers done");
    wr(`OFS_MAIN_CTRL, 8'hc0);
    for (int b = 0; b < 4; b++)
    begin
      for (int i = 0; i < 8; i++)
        if (impl[b][i])
        begin
          wr(4'(b), 8'h01 << i);
          fi(b, ~(8'h01 << i));
          ic(1'b0);
          rc(4'(b + 4), ~(8'h01 << i) & impl[b]);
          fi(b, 8'h01 << i);
          ic(1'b1);
          rc(`OFS_STATUS, 8'h03);
          wr(4'(b + 4), 8'hff);
          ic(1'b0);
        end
      wr(4'(b), 8'h00);
    end
    $display("test source map done");
    wr(`OFS_ENABLE_1, 8'h40);
    wr(`OFS_MAIN_CTRL, 8'h80);
    fi(0, 8'h40);
    ic(1'b0);
    rc(`OFS_FLAG_1, 8'h40);
    rc(`OFS_STATUS, 8'h02);
    wr(`OFS_MAIN_CTRL, 8'hc0);
    ic(1'b1);
    wr(`OFS_MAIN_CTRL, 8'h40);
    ic(1'b0);
    ack_en <= 1'b1;
    wr(`OFS_MAIN_CTRL, 8'hc0);
    repeat (3) @(posedge clock);
    ic(1'b0);
    rc(`OFS_MAIN_CTRL, 8'h40);
    ack_en <= 1'b0;
    irq_return <= 1'b1;
    @(posedge clock);
    irq_return <= 1'b0;
    @(posedge clock);
    ic(1'b1);
    wr(`OFS_FLAG_1, 8'h40);
    ic(1'b0);
    $display("test gating done");
    results();
  end
endmodule
